/* File: port_pin_config_regs.sv */
// Purpose: Port 0 driver setup and port 1 data, skip and input mode registers
// Assumes: Core register bus with page selector; pins sampled through synchroniser
// Notes:   Pin drive outputs except p0HighDrive are registered, one cycle behind the registers
//
// What this block does
// - Port 0 mode bit: open-drain or push-pull
// - Mode bit drives even in analog mode
// - Port 0 drive bit: low or high
// - Address A4 split by page zero, F
// - Port 1 data write loads latch
// - Port 1 data read returns pins
// - Port 1 data: 90, all pages, bit-addressable
// - Skip bit set makes crossbar skip
// - Input mode zero: analog, pullup off
// - Input mode at F2, page zero, ones
// - Bit n acts on pin n only
// - Radio and unconnected pins mapped fixed
// - Read-modify-write reads latch not pins
// - Serial bus pins always open-drain
`timescale 1ns/100ps
`default_nettype none
module port_pin_config_regs
  import port_cfg_pkg::*;
#(
  parameter int PORT_W_P = 8
) (
  // Clock, reset, enable
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // Register bus
  input  wire sfrReq_t       sfrReq,
  output logic [7:0]         sfrRdData,
  output logic               sfrRdValid,
  output logic               sfrRdHit,
  // Port 0 driver inputs from same-clock logic
  input  wire logic [7:0]    p0OutData,
  input  wire logic [7:0]    p0SerialMask,
  // Port 0 pin drive
  output logic [7:0]         p0PinOut,
  output logic [7:0]         p0PinOe,
  output logic [7:0]         p0HighDrive,
  output logic [7:0]         p0RadioOut,
  output logic [7:0]         p0RadioOe,
  // Port 1 pins (radio side and unconnected)
  input  wire logic [7:0]    p1PinIn,
  output logic [7:0]         p1PinOut,
  output logic [7:0]         p1PinOe,
  output logic [7:0]         p1PullupEn,
  output logic [7:0]         p1RxEn,
  // Crossbar side
  output logic [7:0]         p1SkipOut,
  output logic [7:0]         p0ModeOut
);

  if (PORT_W_P != PORT_W) begin : badWidth
    $error("port_pin_config_regs: port width must be 8");
  end

  portCfg_t   cfg_q;
  portCfg_t   cfg_d;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic       rdValid_q;
  logic       rdValid_d;
  logic       rdHit_q;
  logic       rdHit_d;
  logic [7:0] p0Out_q;
  logic [7:0] p0Out_d;
  logic [7:0] p0Oe_q;
  logic [7:0] p0Oe_d;
  logic [7:0] p1Out_q;
  logic [7:0] p1Out_d;
  logic [7:0] p1Oe_q;
  logic [7:0] p1Oe_d;
  logic [7:0] p1Pull_q;
  logic [7:0] p1Pull_d;
  logic [7:0] p1Rx_q;
  logic [7:0] p1Rx_d;
  logic [7:0] p1Sync;
  logic [7:0] pinLevel;
  logic [7:0] pushPull;
  logic       hitData;
  logic       hitMode;
  logic       hitDrv;
  logic       hitSkip;
  logic       hitIn;

  assign hitData = (sfrReq.addr == ADDR_P1_DATA);
  assign hitMode = (sfrReq.addr == ADDR_P0_MODDRV) && (sfrReq.page == PAGE_CFG);
  assign hitDrv  = (sfrReq.addr == ADDR_P0_MODDRV) && (sfrReq.page == PAGE_DRV);
  assign hitSkip = (sfrReq.addr == ADDR_P1_SKIP) && (sfrReq.page == PAGE_CFG);
  assign hitIn   = (sfrReq.addr == ADDR_P1_INMODE) && (sfrReq.page == PAGE_CFG);

  // Register writes
  always_comb begin
    cfg_d = cfg_q;
    if (sfrReq.wr) begin
      if (hitMode) begin
        cfg_d.p0Mode = sfrReq.wdata;
      end
      if (hitDrv) begin
        cfg_d.p0Drive = sfrReq.wdata;
      end
      if (hitData) begin
        cfg_d.p1Latch = sfrReq.wdata;
      end
      if (hitSkip) begin
        cfg_d.port1_crossbar_skip = sfrReq.wdata;
      end
      if (hitIn) begin
        cfg_d.p1InMode = sfrReq.wdata;
      end
    end else if (sfrReq.bitWr && hitData) begin
      cfg_d.p1Latch[sfrReq.bitIdx] = sfrReq.bitVal;
    end
  end

  // Register reads, answered one cycle later
  always_comb begin
    rdData_d  = RST_RDATA;
    rdHit_d   = 1'b0;
    rdValid_d = sfrReq.rd;
    if (sfrReq.rd) begin
      rdHit_d = hitData | hitMode | hitDrv | hitSkip | hitIn;
      if (hitData) begin
        rdData_d = sfrReq.rmw ? cfg_q.p1Latch : pinLevel;
      end else if (hitMode) begin
        rdData_d = cfg_q.p0Mode;
      end else if (hitDrv) begin
        rdData_d = cfg_q.p0Drive;
      end else if (hitSkip) begin
        rdData_d = cfg_q.port1_crossbar_skip;
      end else if (hitIn) begin
        rdData_d = cfg_q.p1InMode;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q     <= CFG_RESET;
      rdData_q  <= RST_RDATA;
      rdValid_q <= 1'b0;
      rdHit_q   <= 1'b0;
    end else if (ce) begin
      cfg_q     <= cfg_d;
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
      rdHit_q   <= rdHit_d;
    end
  end

  port_pin_sync #(
    .WIDTH     (PORT_W),
    .RESET_VAL (RST_SYNC)
  ) u_p1Sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .din     (p1PinIn),
    .dout    (p1Sync)
  );

  // Per-pin drivers; bit n touches pin n only
  for (genvar i = 0; i < PORT_W; i++) begin : pinGen
    assign pushPull[i] = cfg_q.p0Mode[i] & ~p0SerialMask[i];
    always_comb begin
      p0Out_d[i] = p0OutData[i];
      p0Oe_d[i]  = pushPull[i] | ~p0OutData[i];
      p1Out_d[i] = cfg_q.p1Latch[i];
      p1Oe_d[i]  = ~cfg_q.p1Latch[i] & ~NC_P1_MASK[i];
      p1Pull_d[i] = cfg_q.p1InMode[i] & ~NC_P1_MASK[i];
      p1Rx_d[i]   = cfg_q.p1InMode[i] & ~NC_P1_MASK[i];
    end
    // Receiver off reads low, avoids floating analog levels
    assign pinLevel[i] = p1Sync[i] & p1Rx_q[i];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p0Out_q  <= RST_SYNC;
      p0Oe_q   <= RST_P0_MODE;
      p1Out_q  <= RST_P1_LATCH;
      p1Oe_q   <= RST_P0_MODE;
      p1Pull_q <= RST_P1_INMODE & ~NC_P1_MASK;
      p1Rx_q   <= RST_P1_INMODE & ~NC_P1_MASK;
    end else if (ce) begin
      p0Out_q  <= p0Out_d;
      p0Oe_q   <= p0Oe_d;
      p1Out_q  <= p1Out_d;
      p1Oe_q   <= p1Oe_d;
      p1Pull_q <= p1Pull_d;
      p1Rx_q   <= p1Rx_d;
    end
  end

  // port 0 pin 7 goes to the radio
  assign p0PinOut    = p0Out_q & ~RADIO_P0_MASK;
  assign p0PinOe     = p0Oe_q & ~RADIO_P0_MASK;
  assign p0RadioOut  = p0Out_q & RADIO_P0_MASK;
  assign p0RadioOe   = p0Oe_q & RADIO_P0_MASK;
  assign p0HighDrive = cfg_q.p0Drive;
  assign p1PinOut    = p1Out_q;
  assign p1PinOe     = p1Oe_q;
  assign p1PullupEn  = p1Pull_q;
  assign p1RxEn      = p1Rx_q;
  assign p1SkipOut   = cfg_q.port1_crossbar_skip;
  assign p0ModeOut   = cfg_q.p0Mode;
  assign sfrRdData   = rdData_q;
  assign sfrRdValid  = rdValid_q;
  assign sfrRdHit    = rdHit_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence modeWrite;
    ce && sfrReq.wr && hitMode;
  endsequence

  sequence drvWrite;
    ce && sfrReq.wr && hitDrv;
  endsequence

  sequence dataWrite;
    ce && sfrReq.wr && hitData;
  endsequence

  sequence rmwRead;
    ce && sfrReq.rd && sfrReq.rmw && hitData;
  endsequence

  modeWrite_a: assert property (modeWrite |=> cfg_q.p0Mode == $past(sfrReq.wdata))
    else $error("output mode not written");

  pageSplit_a: assert property (drvWrite |=>
      cfg_q.p0Drive == $past(sfrReq.wdata) && $stable(cfg_q.p0Mode))
    else $error("page split at shared address wrong");

  pageGuard_a: assert property (ce && sfrReq.wr && sfrReq.addr == ADDR_P1_SKIP &&
      sfrReq.page != PAGE_CFG |=> $stable(cfg_q.port1_crossbar_skip))
    else $error("skip written on wrong page");

  pinRead_a: assert property (ce && sfrReq.rd && !sfrReq.rmw && hitData |=>
      sfrRdValid && sfrRdData == $past(pinLevel))
    else $error("data read not from pins");

  latchBack_a: assert property (dataWrite ##1 rmwRead |=>
      sfrRdData == $past(sfrReq.wdata, 2))
    else $error("rmw read not from latch");

  odDrive_a: assert property (ce |=>
      p0Oe_q == $past(pushPull | ~p0OutData))
    else $error("port 0 driver type wrong");

  serialOd_a: assert property (ce |=>
      (p0Oe_q & $past(p0SerialMask)) == $past(~p0OutData & p0SerialMask))
    else $error("serial pin not open-drain");

  analogPull_a: assert property (ce |=>
      (p1Pull_q & $past(~cfg_q.p1InMode)) == 8'h00)
    else $error("pullup on in analog mode");

  bitWrite_a: assert property (ce && sfrReq.bitWr && !sfrReq.wr && hitData |=>
      cfg_q.p1Latch[$past(sfrReq.bitIdx)] == $past(sfrReq.bitVal))
    else $error("bit write lost");

  resetVals_a: assert property ($fell(sys_rst) |-> cfg_q == CFG_RESET)
    else $error("reset values wrong");

endmodule : port_pin_config_regs
`default_nettype wire

/* File: port_cfg_pkg.sv */
// Purpose: Shared constants and types for the port pin configuration block
// Assumes: 8-bit special function register bus with a 4-bit page selector
// Notes:   Offsets, page codes, reset values and pin maps live here only
package port_cfg_pkg;

  localparam int         PORT_W         = 8;
  localparam int         SYNC_STAGES    = 3;

  // Register addresses
  localparam logic [7:0] ADDR_P1_DATA   = 8'h90;
  localparam logic [7:0] ADDR_P0_MODDRV = 8'hA4;
  localparam logic [7:0] ADDR_P1_SKIP   = 8'hD5;
  localparam logic [7:0] ADDR_P1_INMODE = 8'hF2;

  // Register pages
  localparam logic [3:0] PAGE_CFG       = 4'h0;
  localparam logic [3:0] PAGE_DRV       = 4'hF;

  // Reset values
  localparam logic [7:0] RST_P0_MODE    = 8'h00;
  localparam logic [7:0] RST_P0_DRIVE   = 8'h00;
  localparam logic [7:0] RST_P1_LATCH   = 8'hFF;
  localparam logic [7:0] RST_P1_SKIP    = 8'h00;
  localparam logic [7:0] RST_P1_INMODE  = 8'hFF;
  localparam logic [7:0] RST_SYNC       = 8'hFF;
  localparam logic [7:0] RST_RDATA      = 8'h00;

  // Pin maps: radio-connected and unconnected pins
  localparam logic [7:0] RADIO_P0_MASK  = 8'h80;
  localparam logic [7:0] RADIO_P1_MASK  = 8'hE4;
  localparam logic [7:0] NC_P1_MASK     = 8'h1B;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       rmw;
    logic       bitWr;
    logic [2:0] bitIdx;
    logic       bitVal;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrReq_t;

  typedef struct packed {
    logic [7:0] p0Mode;
    logic [7:0] p0Drive;
    logic [7:0] p1Latch;
    logic [7:0] port1_crossbar_skip;
    logic [7:0] p1InMode;
  } portCfg_t;

  localparam portCfg_t CFG_RESET = '{
    p0Mode:   RST_P0_MODE,
    p0Drive:  RST_P0_DRIVE,
    p1Latch:  RST_P1_LATCH,
    port1_crossbar_skip:   RST_P1_SKIP,
    p1InMode: RST_P1_INMODE
  };

endpackage : port_cfg_pkg

/* File: port_pin_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module port_pin_sync #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RESET_VAL = 8'hFF
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // Pin side
  input  wire logic [WIDTH-1:0] din,
  // Core side
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  // First stage feeds only the second
  always_comb begin
    stable_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stable_q);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q   <= RESET_VAL[WIDTH-1:0];
      s2_q     <= RESET_VAL[WIDTH-1:0];
      s3_q     <= RESET_VAL[WIDTH-1:0];
      stable_q <= RESET_VAL[WIDTH-1:0];
    end else if (ce) begin
      meta_q   <= din;
      s2_q     <= meta_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
    end
  end

  assign dout = stable_q;

endmodule : port_pin_sync
`default_nettype wire

/* File: pin_far_model.sv */
// Purpose: Far side of the port 1 pins: radio drivers, pullups, floating pads
// Assumes: Device drives open-drain low only while its enable is high
// Notes:   Floating pads toggle each cycle so a stale value never reads back
`timescale 1ns/100ps
`default_nettype none
module pin_far_model (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pullupEn,
  // Bench control of external drivers
  input  wire logic [7:0] extDrive,
  input  wire logic [7:0] extLevel,
  // Resolved wire
  output logic      [7:0] pinLevel
);
  logic [7:0] floatQ = 8'h55;
  logic [7:0] freeLevel;

  always_ff @(posedge clk) begin
    floatQ <= ~floatQ;
  end

  assign freeLevel = (extDrive & extLevel) | (~extDrive & (pullupEn | floatQ & ~pullupEn));
  assign pinLevel  = freeLevel & ~(pinOe & ~pinOut);
endmodule : pin_far_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the port pin configuration registers
// Assumes: Read answer stands exactly one edge after a taken request
// Notes:   Pin levels resolved by the far-side pin model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import port_cfg_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic       ce;
  sfrReq_t    sfrReq;
  logic [7:0] p0OutData, p0SerialMask, p1PinIn, extDrive, extLevel, rdData;
  logic [7:0] sfrRdData, p0PinOut, p0PinOe, p0HighDrive, p0RadioOut, p0RadioOe;
  logic [7:0] p1PinOut, p1PinOe, p1PullupEn, p1RxEn, p1SkipOut, p0ModeOut;
  logic       sfrRdValid, sfrRdHit, rdValid, rdHit;
  int         errCount, samplesChecked;

  port_pin_config_regs #(.PORT_W_P(8)) i_dut (.clk, .sys_rst, .ce, .sfrReq,
    .sfrRdData, .sfrRdValid, .sfrRdHit, .p0OutData, .p0SerialMask, .p0PinOut,
    .p0PinOe, .p0HighDrive, .p0RadioOut, .p0RadioOe, .p1PinIn, .p1PinOut,
    .p1PinOe, .p1PullupEn, .p1RxEn, .p1SkipOut, .p0ModeOut);

  pin_far_model i_pins (.clk, .pinOut(p1PinOut), .pinOe(p1PinOe),
    .pullupEn(p1PullupEn), .extDrive, .extLevel, .pinLevel(p1PinIn));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Request held one cycle, answer sampled after the edge that takes it
  task automatic bus(input logic r, w, m, b, input logic [2:0] idx, input logic v,
                     input logic [3:0] pg, input logic [7:0] a, d);
    @(posedge clk);
    sfrReq <= '{rd: r, wr: w, rmw: m, bitWr: b, bitIdx: idx, bitVal: v,
                page: pg, addr: a, wdata: d};
    @(posedge clk);
    sfrReq <= '0;
    #1;
    rdData = sfrRdData;
    rdValid = sfrRdValid;
    rdHit = sfrRdHit;
  endtask : bus

  task automatic wrReg(input logic [3:0] pg, input logic [7:0] a, d);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, pg, a, d);
  endtask : wrReg

  task automatic rdChk(input logic [3:0] pg, input logic [7:0] a, input logic m,
                       input logic [7:0] expD, input logic expH);
    bus(1'b1, 1'b0, m, 1'b0, 3'h0, 1'b0, pg, a, 8'h00);
    chk1(rdValid, 1'b1);
    chk1(rdHit, expH);
    chk8(rdData, expD);
  endtask : rdChk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic test_reset;
    rdChk(PAGE_CFG, ADDR_P0_MODDRV, 1'b0, 8'h00, 1'b1);
    rdChk(PAGE_DRV, ADDR_P0_MODDRV, 1'b0, 8'h00, 1'b1);
    rdChk(PAGE_CFG, ADDR_P1_SKIP, 1'b0, 8'h00, 1'b1);
    rdChk(PAGE_CFG, ADDR_P1_INMODE, 1'b0, 8'hFF, 1'b1);
    rdChk(4'h5, ADDR_P1_DATA, 1'b1, 8'hFF, 1'b1);
    chk8(p1PullupEn, 8'hE4);
    chk8(p0PinOe, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_paging;
    wrReg(PAGE_CFG, ADDR_P0_MODDRV, 8'h5B);
    wrReg(PAGE_DRV, ADDR_P0_MODDRV, 8'hC3);
    wrReg(PAGE_DRV, ADDR_P1_SKIP, 8'h77);
    rdChk(PAGE_CFG, ADDR_P0_MODDRV, 1'b0, 8'h5B, 1'b1);
    rdChk(PAGE_DRV, ADDR_P0_MODDRV, 1'b0, 8'hC3, 1'b1);
    rdChk(PAGE_CFG, ADDR_P1_SKIP, 1'b0, 8'h00, 1'b1);
    rdChk(PAGE_DRV, ADDR_P1_SKIP, 1'b0, 8'h00, 1'b0);
    rdChk(PAGE_CFG, 8'h91, 1'b0, 8'h00, 1'b0);
    chk8(p0ModeOut, 8'h5B);
    chk8(p0HighDrive, 8'hC3);
    $display("test_paging done");
  endtask : test_paging

  // Mode 5B, serial pin 0, data 0F: enables 7A with radio pin 7 masked
  task automatic test_driver;
    @(posedge clk);
    p0OutData <= 8'h0F;
    p0SerialMask <= 8'h01;
    settle(3);
    chk8(p0PinOe, 8'h7A);
    chk8(p0PinOut, 8'h0F);
    chk8(p0RadioOe, 8'h80);
    chk8(p0RadioOut, 8'h00);
    $display("test_driver done");
  endtask : test_driver

  task automatic test_data;
    wrReg(4'h9, ADDR_P1_DATA, 8'h00);
    settle(2);
    chk8(p1PinOe, 8'hE4);
    chk8(p1PinOut, 8'h00);
    settle(6);
    rdChk(PAGE_CFG, ADDR_P1_DATA, 1'b0, 8'h00, 1'b1);
    wrReg(PAGE_DRV, ADDR_P1_DATA, 8'hFF);
    settle(8);
    rdChk(PAGE_CFG, ADDR_P1_DATA, 1'b0, 8'hE4, 1'b1);
    @(posedge clk);
    extDrive <= 8'hE4;
    extLevel <= 8'h24;
    settle(8);
    rdChk(4'h3, ADDR_P1_DATA, 1'b0, 8'h24, 1'b1);
    rdChk(4'h3, ADDR_P1_DATA, 1'b1, 8'hFF, 1'b1);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 3'h6, 1'b0, 4'h7, ADDR_P1_DATA, 8'h00);
    rdChk(4'h2, ADDR_P1_DATA, 1'b1, 8'hBF, 1'b1);
    chk8(p1PinOe, 8'h40);
    $display("test_data done");
  endtask : test_data

  task automatic test_inmode;
    wrReg(PAGE_CFG, ADDR_P1_INMODE, 8'h20);
    settle(8);
    chk8(p1PullupEn, 8'h20);
    chk8(p1RxEn, 8'h20);
    rdChk(PAGE_CFG, ADDR_P1_DATA, 1'b0, 8'h20, 1'b1);
    rdChk(PAGE_CFG, ADDR_P1_INMODE, 1'b0, 8'h20, 1'b1);
    wrReg(PAGE_CFG, ADDR_P1_SKIP, 8'hA5);
    chk8(p1SkipOut, 8'hA5);
    $display("test_inmode done");
  endtask : test_inmode

  // Frozen clock enable ignores a write; then write and rmw read back to back
  task automatic test_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wrReg(PAGE_CFG, ADDR_P1_SKIP, 8'h5A);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk8(p1SkipOut, 8'hA5);
    @(posedge clk);
    sfrReq <= '{rd: 1'b0, wr: 1'b1, rmw: 1'b0, bitWr: 1'b0, bitIdx: 3'h0, bitVal: 1'b0,
                page: 4'h6, addr: ADDR_P1_DATA, wdata: 8'h3C};
    @(posedge clk);
    sfrReq <= '{rd: 1'b1, wr: 1'b0, rmw: 1'b1, bitWr: 1'b0, bitIdx: 3'h0, bitVal: 1'b0,
                page: 4'h6, addr: ADDR_P1_DATA, wdata: 8'h00};
    @(posedge clk);
    sfrReq <= '0;
    #1;
    chk1(sfrRdValid, 1'b1);
    chk8(sfrRdData, 8'h3C);
    $display("test_freeze done");
  endtask : test_freeze

  task automatic finish_test;
    $display("checks=%0d errors=%0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Tests need about a hundred cycles; 10000 means a hang
  initial begin
    #40000;
    errCount++;
    finish_test();
  end

  initial begin
    errCount = 0;
    samplesChecked = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    sfrReq = '0;
    p0OutData = 8'hFF;
    p0SerialMask = 8'h00;
    extDrive = 8'h00;
    extLevel = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset();
    test_paging();
    test_driver();
    test_data();
    test_inmode();
    test_freeze();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
